// *** rtl/pkr_regs.svh ***
// Constants for the keyboard receiver: timing counts and reset values.
// Assumes inclusion by the receiver's design files only.
`ifndef PKR_REGS_SVH
`define PKR_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PKR_SYS_CLK_HZ 125000000
`define PKR_LINK_CLK_HZ 10000
// Idle-high time that ends a frame: half a link clock period plus one cycle
`define PKR_IDLE_CYCLES (`PKR_SYS_CLK_HZ / `PKR_LINK_CLK_HZ / 2 + 1)
`define PKR_DEB_CYCLES 8
`define PKR_FRAME_BITS 11
`define PKR_FIFO_DEPTH 4
`define PKR_DATA_W 8
`define PKR_DATA_RST 8'h00

`endif

// *** rtl/pkr_pkg.sv ***
// Types shared by the keyboard receiver files.
// Assumes pkr_regs.svh is on the include path.
`include "pkr_regs.svh"
package pkr_pkg;
  typedef logic [`PKR_DATA_W-1:0] pkr_byte_t;
  typedef struct packed {
    logic clk;
    logic dat;
  } pkr_link_t;
  typedef enum logic [0:0] {PKR_IDLE, PKR_FRAME} pkr_state_t;
endpackage

// *** rtl/pkr_debounce.sv ***
// One line filter: two-flop synchroniser then a stability counter.
// Assumes an asynchronous line and the system clock.
`timescale 1ns/10ps
module pkr_debounce #(
  parameter int CNT = 8,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_in,
  output logic line_out
);
  logic meta_q;
  logic sync_q;
  logic [$clog2(CNT+1)-1:0] cnt_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= line_in;
      sync_q <= meta_q;
    end
  end

  // A level only passes after CNT stable samples, so glitches vanish
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      line_out <= RST_VAL;
    end else if (sync_q == line_out) begin
      cnt_q <= '0;
    end else if (cnt_q == ($clog2(CNT+1))'(CNT - 1)) begin
      cnt_q <= '0;
      line_out <= sync_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// *** rtl/pkr_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; full and empty are exact.
`timescale 1ns/10ps
module pkr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** rtl/pkr_receiver.sv ***
// Keyboard frame receiver with a byte queue read over a chip-selected bus.
// Assumes keyboard lines asynchronous to core_clk; host drives cs_in and
// clear_int_in from its own logic, sampled through synchronisers here.
//
// Overview of operation
// [RULE1] Both keyboard lines are synchronised and debounced before any decision.
// [RULE2] Each falling edge of the filtered link clock shifts the data bit into an 11-bit frame.
// [RULE3] A frame ends once the link clock stays high longer than half a 10 kHz period.
// [RULE4] Frame completion drives the valid strobe high for exactly one cycle.
// [RULE5] The valid strobe writes the received byte into the FIFO.
// [RULE6] The valid strobe sets the interrupt, which stays set until cleared.
// [RULE7] Data-ready goes high one cycle after the FIFO holds an unread byte and low one cycle after it empties.
// [RULE8] A chip-select read presents the FIFO head byte on the byte bus.
// [RULE9] Byte-bus drivers are enabled only while chip select is asserted; bus input is ignored.
// [RULE10] Clear-interrupt high clears the interrupt unless a new strobe arrives that cycle.
// [RULE11] The eight bits after the start bit are queued LSB first; one byte pops per read.
`timescale 1ns/10ps
`include "pkr_regs.svh"
module pkr_receiver (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic kbd_clk_in,
  input wire logic kbd_data_in,
  input wire logic clear_int_in,
  input wire logic cs_in,
  input wire logic [7:0] bus_in,
  output logic valid_out,
  output logic irq_out,
  output logic data_rdy_out,
  output logic [7:0] bus_out,
  output logic [7:0] bus_oe
);
  localparam int IDLE_W = $clog2(`PKR_IDLE_CYCLES + 1);

  // ----------------------------------------
  // Line filters
  // ----------------------------------------
  pkr_pkg::pkr_link_t link;

  pkr_debounce #(.CNT(`PKR_DEB_CYCLES), .RST_VAL(1'b1)) u_deb_clk ( // see [RULE1]
    .core_clk(core_clk),
    .rst(rst),
    .line_in(kbd_clk_in),
    .line_out(link.clk)
  );

  pkr_debounce #(.CNT(`PKR_DEB_CYCLES), .RST_VAL(1'b1)) u_deb_dat ( // see [RULE1]
    .core_clk(core_clk),
    .rst(rst),
    .line_in(kbd_data_in),
    .line_out(link.dat)
  );

  // Host strobes are treated as pins: two flops each
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic clr_meta_q;
  logic clr_sync_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_meta_q <= 1'b0;
      cs_sync_q <= 1'b0;
      cs_prev_q <= 1'b0;
      clr_meta_q <= 1'b0;
      clr_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= cs_in;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      clr_meta_q <= clear_int_in;
      clr_sync_q <= clr_meta_q;
    end
  end

  // ----------------------------------------
  // Frame shifter
  // ----------------------------------------
  logic clk_prev_q;
  logic fall;
  logic [`PKR_FRAME_BITS-1:0] shift_q;
  logic [IDLE_W-1:0] idle_q;
  pkr_pkg::pkr_state_t state_q;
  logic done;

  assign fall = clk_prev_q && !link.clk;
  assign done = (state_q == pkr_pkg::PKR_FRAME) && link.clk
    && (idle_q == IDLE_W'(`PKR_IDLE_CYCLES));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= link.clk;
    end
  end

  // New bits enter at the top so the first bit ends at index 0
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
    end else if (fall) begin
      shift_q <= {link.dat, shift_q[`PKR_FRAME_BITS-1:1]}; // see [RULE2]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_q <= '0;
    end else if (!link.clk) begin
      idle_q <= '0;
    end else if (idle_q != IDLE_W'(`PKR_IDLE_CYCLES)) begin
      idle_q <= idle_q + 1'b1; // see [RULE3]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= pkr_pkg::PKR_IDLE;
    end else begin
      unique case (state_q)
        pkr_pkg::PKR_IDLE: begin
          if (fall) begin
            state_q <= pkr_pkg::PKR_FRAME;
          end
        end
        pkr_pkg::PKR_FRAME: begin
          if (done) begin
            state_q <= pkr_pkg::PKR_IDLE; // see [RULE3]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Strobe, queue and interrupt
  // ----------------------------------------
  logic valid_q;
  pkr_pkg::pkr_byte_t byte_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  pkr_pkg::pkr_byte_t fifo_out_data;
  logic rd_pop;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
      byte_q <= `PKR_DATA_RST;
    end else begin
      valid_q <= done; // see [RULE4]
      if (done) begin
        byte_q <= shift_q[8:1]; // see [RULE11]
      end
    end
  end

  assign valid_out = valid_q;
  // One pop per chip-select assertion, on its rising edge
  assign rd_pop = cs_sync_q && !cs_prev_q; // see [RULE11]

  // A full queue drops the new byte; a keyboard cannot be stalled
  pkr_fifo #(.W(`PKR_DATA_W), .DEPTH(`PKR_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(byte_q),
    .in_valid(valid_q), // see [RULE5]
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(rd_pop)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else if (valid_q) begin
      irq_out <= 1'b1; // see [RULE6] [RULE10]
    end else if (clr_sync_q) begin
      irq_out <= 1'b0; // see [RULE10]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_rdy_out <= 1'b0;
    end else begin
      data_rdy_out <= fifo_out_valid; // see [RULE7]
    end
  end

  // ----------------------------------------
  // Host byte bus
  // ----------------------------------------
  // The head byte is latched at the read so it holds while cs stays high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_out <= `PKR_DATA_RST;
      bus_oe <= 8'h00;
    end else begin
      bus_oe <= {8{cs_sync_q}}; // see [RULE9]
      if (rd_pop) begin
        bus_out <= fifo_out_valid ? fifo_out_data : `PKR_DATA_RST; // see [RULE8]
      end
    end
  end

  logic unused_ok;
  assign unused_ok = fifo_in_ready ^ (^bus_in);
endmodule

// *** dv/pkr_kbd_model.sv ***
// Keyboard model: one frame per send call, both lines idle high.
// Assumes core_clk paces it; each bit of the link clock is 17 cycles high, then 16 low.
`timescale 1ns/10ps
module pkr_kbd_model (
  input wire logic core_clk,
  output pkr_pkg::pkr_link_t link
);
  initial link = 2'b11;
  // Start, data LSB first, odd parity, stop; stop leaves data at pull-up
  task automatic send(input pkr_pkg::pkr_byte_t b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk);
      link.dat <= f[i];
      repeat (16) @(posedge core_clk);
      link.clk <= 1'b0;
      repeat (16) @(posedge core_clk);
      link.clk <= 1'b1;
    end
  endtask
endmodule

// *** dv/pkr_receiver_chk.sv ***
// Port checker for the keyboard receiver, bound below.
// Assumes cs and clear pass two synchroniser flops inside.
`timescale 1ns/10ps
module pkr_receiver_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic kbd_clk_in,
  input wire logic clear_int_in,
  input wire logic cs_in,
  input wire logic valid_out,
  input wire logic irq_out,
  input wire logic data_rdy_out,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe
);
  // Raw high time of the link clock, saturating
  logic [15:0] hi_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) hi_q <= 16'h0000;
    else if (!kbd_clk_in) hi_q <= 16'h0000;
    else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h0001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rd_s; $rose(cs_in) ##1 cs_in [*3]; endsequence
  sequence quiet_s; !cs_in [*5]; endsequence
  valid_pulse_a: assert property (valid_out |=> !valid_out)
    else $error("strobe too long");
  irq_set_a: assert property (valid_out |=> irq_out)
    else $error("irq not set");
  irq_clear_a: assert property ($fell(irq_out) |->
    $past(clear_int_in, 2) || $past(clear_int_in, 3) || $past(clear_int_in, 4))
    else $error("irq fell uncleared");
  oe_on_a: assert property (rd_s |-> bus_oe == 8'hff)
    else $error("bus not driven");
  oe_off_a: assert property (quiet_s |-> bus_oe == 8'h00)
    else $error("bus driven idle");
  out_hold_a: assert property (quiet_s |-> $stable(bus_out))
    else $error("bus data moved");
  rdy_after_a: assert property (valid_out |-> ##[1:3] data_rdy_out)
    else $error("ready missing");
  idle_gap_a: assert property (valid_out |-> hi_q >= 16'h186b)
    else $error("frame ended early");
endmodule

bind pkr_receiver pkr_receiver_chk chk (.core_clk, .rst, .kbd_clk_in, .clear_int_in,
  .cs_in, .valid_out, .irq_out, .data_rdy_out, .bus_out, .bus_oe);

// *** dv/pkr_receiver_bench.sv ***
// Bench for the keyboard receiver: model frames, host reads and clears.
// Assumes the keyboard model and the checker are compiled first.
`timescale 1ns/10ps
module pkr_receiver_bench;
  logic core_clk, rst, clear_int_in, cs_in, valid_out, irq_out, data_rdy_out;
  logic [7:0] bus_in, bus_out, bus_oe;
  pkr_pkg::pkr_link_t link;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  pkr_kbd_model kbd (.core_clk, .link);
  pkr_receiver dut (.core_clk, .rst, .kbd_clk_in(link.clk), .kbd_data_in(link.dat),
    .clear_int_in, .cs_in, .bus_in, .valid_out, .irq_out, .data_rdy_out, .bus_out, .bus_oe);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard: six frames need about 40000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ----
  // Scenarios
  // ----
  task automatic get_frame(input logic [7:0] b);
    int i;
    kbd.send(b);
    for (i = 0; i < 7000 && valid_out !== 1'b1; i++) @(negedge core_clk);
    chk({6'h00, valid_out, i > 6200}, 8'h03);
    @(negedge core_clk);
    chk({6'h00, valid_out, irq_out}, 8'h01);
  endtask
  // Bus input carries junk that must not matter
  task automatic rd(input logic [7:0] exp);
    @(posedge core_clk);
    cs_in <= 1'b1;
    bus_in <= ~exp;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(bus_out, exp);
    chk(bus_oe, 8'hff);
    @(posedge core_clk);
    cs_in <= 1'b0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk(bus_oe, 8'h00);
  endtask
  task automatic clr();
    @(posedge core_clk);
    clear_int_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    clear_int_in <= 1'b0;
    @(negedge core_clk);
    chk({7'h00, irq_out}, 8'h00);
  endtask
  task automatic t_single();
    get_frame(8'ha5);
    repeat (3) @(negedge core_clk);
    chk({7'h00, data_rdy_out}, 8'h01);
    rd(8'ha5);
    chk({6'h00, data_rdy_out, irq_out}, 8'h01);
    clr();
  endtask
  // Fifth byte meets a full queue and is dropped
  task automatic t_fill();
    logic [7:0] v[5] = '{8'h01, 8'h80, 8'h3c, 8'hff, 8'h5a};
    foreach (v[k]) get_frame(v[k]);
    for (int k = 0; k < 4; k++) rd(v[k]);
    chk({7'h00, data_rdy_out}, 8'h00);
    rd(8'h00);
    clr();
  endtask
  initial begin
    rst = 1'b1;
    clear_int_in = 1'b0;
    cs_in = 1'b0;
    bus_in = 8'h00;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk({5'h00, valid_out, irq_out, data_rdy_out}, 8'h00);
    chk(bus_oe | bus_out, 8'h00);
    t_single();
    t_fill();
    stop_test();
  end
endmodule
